// ===== core/level_filter_clamp_power_regs.sv
// register bank for level loop filter, fine clamp and power control
// assumes a classic wishbone master; clamp mode selection arrives from
// neighbouring register logic on the same clock
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module level_filter_clamp_power_regs
    import level_regs_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [9:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    input wire logic coarse_clamp_sel_in,
    input wire logic mid_level_clamp_sel_in,
    input wire logic sample_valid_in,
    input wire logic [9:0] sample_in,
    input wire logic line_update_in,
    output logic [3:0] vertical_filter_coeff_out,
    output logic [2:0] horizontal_filter_taps_out,
    output logic automatic_level_loop_en_out,
    output logic [9:0] level_out,
    output logic common_mode_offset_en_out,
    output logic [1:0] fine_clamp_time_const_out,
    output logic fine_clamp_green_blue_en_out,
    output logic fine_clamp_red_en_out,
    output logic sog_power_down_out,
    output logic slicer_power_down_out,
    output logic reference_power_down_out,
    output logic current_ctrl_power_down_out,
    output logic blue_converter_power_down_out,
    output logic green_converter_power_down_out,
    output logic red_converter_power_down_out
);
    // -------------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------------
    logic [7:0] loop_enable_r;
    logic [7:0] loop_filter_r;
    logic [7:0] fixed_r;
    logic [7:0] clamp_r;
    logic [7:0] power_r;
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;
    logic [9:0] level_w;

    wire req = wb_cyc_in && wb_stb_in && !ack_r && !err_r;
    wire aligned = (wb_adr_in[1:0] == 2'b00);
    wire [7:0] idx = wb_adr_in[9:2];
    wire hit_en = aligned && (idx == IDX_LOOP_ENABLE);
    wire hit_filt = aligned && (idx == IDX_LOOP_FILTER);
    wire hit_fix = aligned && (idx == IDX_FIXED);
    wire hit_clamp = aligned && (idx == IDX_CLAMP);
    wire hit_pow = aligned && (idx == IDX_POWER);
    wire hit_lo = aligned && (idx == IDX_LEVEL_LO);
    wire hit_hi = aligned && (idx == IDX_LEVEL_HI);
    wire hit_any = hit_en | hit_filt | hit_fix | hit_clamp | hit_pow |
                   hit_lo | hit_hi;
    // level words are read-only; writing them is refused
    wire bad = !hit_any || (wb_we_in && (hit_lo || hit_hi));
    wire wr = req && ce_in && wb_we_in && !bad && wb_sel_in[0];

    function automatic logic [7:0] upd(input logic [7:0] cur,
                                       input logic sel);
        upd = (wr && sel) ? wb_dat_in[7:0] : cur;
    endfunction

    wire [7:0] rd_byte = hit_en ? loop_enable_r :
                         hit_filt ? loop_filter_r :
                         hit_fix ? fixed_r :
                         hit_clamp ? clamp_r :
                         hit_pow ? power_r :
                         hit_lo ? level_w[7:0] :
                         hit_hi ? {6'h00, level_w[9:8]} : 8'h00;

    // -------------------------------------------------------------------
    // registers, full 8 bits stored so reserved bits read back
    // -------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            loop_enable_r <= RST_LOOP_ENABLE;
            loop_filter_r <= RST_LOOP_FILTER;
            fixed_r <= RST_FIXED;
            clamp_r <= RST_CLAMP;
            power_r <= RST_POWER;
        end else begin
            loop_enable_r <= upd(loop_enable_r, hit_en);
            loop_filter_r <= upd(loop_filter_r, hit_filt);
            fixed_r <= upd(fixed_r, hit_fix);
            clamp_r <= upd(clamp_r, hit_clamp);
            power_r <= upd(power_r, hit_pow);
        end
    end

    // one wait state, then ack or err for a single cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else if (ce_in) begin
            ack_r <= req && !bad;
            err_r <= req && bad;
            rdata_r <= (req && !bad && !wb_we_in) ? {24'h000000, rd_byte}
                                                  : 32'h00000000;
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_err_out = err_r;
    assign wb_dat_out = rdata_r;

    // -------------------------------------------------------------------
    // level loop
    // -------------------------------------------------------------------
    level_loop_filter #(
        .SAMPLE_W(10)
    ) u_loop (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .enable_in(loop_enable_r[LOOP_EN_BIT]),
        .vert_coeff_in(loop_filter_r[VERT_LSB +: VERT_W]),
        .horz_taps_in(loop_filter_r[HORZ_LSB +: HORZ_W]),
        .sample_valid_in(sample_valid_in),
        .sample_in(sample_in),
        .line_update_in(line_update_in),
        .level_out(level_w)
    );
    assign level_out = level_w;

    // -------------------------------------------------------------------
    // control outputs
    // -------------------------------------------------------------------
    assign vertical_filter_coeff_out = loop_filter_r[VERT_LSB +: VERT_W];
    assign horizontal_filter_taps_out = loop_filter_r[HORZ_LSB +: HORZ_W];
    assign automatic_level_loop_en_out = loop_enable_r[LOOP_EN_BIT];
    // offset only meaningful on the fine bottom-level clamp
    assign common_mode_offset_en_out = clamp_r[CM_OFS_BIT] &&
        !coarse_clamp_sel_in && !mid_level_clamp_sel_in;
    assign fine_clamp_time_const_out = clamp_r[TC_LSB +: 2];
    assign fine_clamp_green_blue_en_out = clamp_r[GB_BIT];
    assign fine_clamp_red_en_out = clamp_r[RED_BIT];
    assign sog_power_down_out = power_r[PD_SOG_BIT];
    assign slicer_power_down_out = power_r[PD_SLICER_BIT];
    assign reference_power_down_out = power_r[PD_REF_BIT];
    assign current_ctrl_power_down_out = power_r[PD_CUR_BIT];
    assign blue_converter_power_down_out = power_r[PD_BLUE_BIT];
    assign green_converter_power_down_out = power_r[PD_GREEN_BIT];
    assign red_converter_power_down_out = power_r[PD_RED_BIT];
endmodule

// ===== core/level_loop_filter.sv
// per-line level loop: running average of samples, then a vertical filter
// assumes samples and line strobe come from logic on the same clock
`timescale 1ns/1ps
module level_loop_filter
    import level_regs_pkg::*;
#(
    parameter int SAMPLE_W = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    input wire logic [3:0] vert_coeff_in,
    input wire logic [2:0] horz_taps_in,
    input wire logic sample_valid_in,
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic line_update_in,
    output logic [9:0] level_out
);
    // the averaging and readback paths are sized for ten-bit samples
    if (SAMPLE_W != 10) begin : g_width_check
        $error("sample width must be 10");
    end

    // -------------------------------------------------------------------
    // horizontal running average
    // -------------------------------------------------------------------
    logic [17:0] hsum_r;
    logic [8:0] hcount_r;
    logic [9:0] havg_r;
    logic have_avg_r;
    logic [24:0] acc_r;
    logic [3:0] vshift;
    wire [8:0] taps = 9'(9'h002 << horz_taps_in);
    wire hdone = sample_valid_in && (hcount_r + 9'h001 == taps);
    wire [17:0] hsum_next = hsum_r + 18'(sample_in);
    // shift amount widened so the 256-tap code does not wrap to zero
    wire [9:0] hsum_avg = 10'(hsum_next >> ({1'b0, horz_taps_in} + 4'h1));

    // codes above ten all saturate at 1/1024
    assign vshift = (vert_coeff_in > VERT_MAX_SHIFT) ? VERT_MAX_SHIFT
                                                     : vert_coeff_in;
    // accumulator holds level scaled by 2^15 so state survives coeff changes
    wire [24:0] target = {havg_r, 15'h0000};
    wire signed [25:0] diff = $signed({1'b0, target}) -
                              $signed({1'b0, acc_r});
    wire signed [25:0] step = diff >>> vshift;
    wire [9:0] level_abs = acc_r[24:15];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hsum_r <= 18'h00000;
            hcount_r <= 9'h000;
            havg_r <= 10'h000;
            have_avg_r <= 1'b0;
        end else if (ce_in && enable_in && sample_valid_in) begin
            if (hdone) begin
                havg_r <= hsum_avg;
                have_avg_r <= 1'b1;
                hsum_r <= 18'h00000;
                hcount_r <= 9'h000;
            end else begin
                hsum_r <= hsum_next;
                hcount_r <= hcount_r + 9'h001;
            end
        end
    end

    // -------------------------------------------------------------------
    // vertical filter, once per line
    // -------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            acc_r <= 25'h0000000;
            // empty accumulator reads as zero minus the midpoint
            level_out <= LEVEL_MIDPOINT;
        end else if (ce_in) begin
            // coefficient sampled only here, accumulator kept
            if (enable_in && line_update_in && have_avg_r) begin
                acc_r <= 25'($signed({1'b0, acc_r}) + step);
            end
            level_out <= level_abs - LEVEL_MIDPOINT;
        end
    end
endmodule

// ===== core/level_regs_pkg.sv
// constants for the level loop filter, clamp and power control register bank
// assumes a classic wishbone slave with byte-index addressing (offset * 4)
//
// Operation
// - a 4-bit vertical coefficient sets the per-line loop gain, 0 is one-line convergence, codes 10 and up give 1/1024.
// - the common-mode offset is applied to the bottom-level clamp only when its enable bit is 1, reset 0.
// - the common-mode offset enable is ignored while the coarse or mid-level clamp is selected.
// - a 2-bit clamp time-constant field runs from 00 longest (reset) to 11 shortest.
// - the green/blue fine clamp enable turns on both channels' fine clamps, reset 1.
// - the red fine clamp enable turns on the red channel's fine clamp, reset 1.
// - reserved bit 2 of the clamp control register resets to 1 and software keeps it at 1, reset 07h.
// - the sync-on-green, slicer, reference and current-control blocks power down when their bit is 1, reset 0.
// - each converter channel powers down when its bit is 1, reset 0.
// - the filtered level is reported as converter output minus 512 in two's complement.
// - the level loop runs only while its enable bit is set, reset 1.
package level_regs_pkg;
    // -------------------------------------------------------------------
    // register indices (byte address is index * 4)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_LOOP_ENABLE = 8'h26;
    localparam logic [7:0] IDX_LOOP_FILTER = 8'h28;
    localparam logic [7:0] IDX_FIXED = 8'h29;
    localparam logic [7:0] IDX_CLAMP = 8'h2A;
    localparam logic [7:0] IDX_POWER = 8'h2B;
    localparam logic [7:0] IDX_LEVEL_LO = 8'h40;
    localparam logic [7:0] IDX_LEVEL_HI = 8'h41;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [7:0] RST_LOOP_ENABLE = 8'h80;
    localparam logic [7:0] RST_LOOP_FILTER = 8'hA3;
    localparam logic [7:0] RST_FIXED = 8'h08;
    localparam logic [7:0] RST_CLAMP = 8'h07;
    localparam logic [7:0] RST_POWER = 8'h00;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int VERT_LSB = 4;
    localparam int VERT_W = 4;
    localparam int HORZ_LSB = 0;
    localparam int HORZ_W = 3;
    localparam int LOOP_EN_BIT = 7;
    localparam int CM_OFS_BIT = 7;
    localparam int TC_LSB = 3;
    localparam int GB_BIT = 1;
    localparam int RED_BIT = 0;
    localparam int PD_SOG_BIT = 6;
    localparam int PD_SLICER_BIT = 5;
    localparam int PD_REF_BIT = 4;
    localparam int PD_CUR_BIT = 3;
    localparam int PD_BLUE_BIT = 2;
    localparam int PD_GREEN_BIT = 1;
    localparam int PD_RED_BIT = 0;

    // -------------------------------------------------------------------
    // level loop arithmetic
    // -------------------------------------------------------------------
    localparam logic [3:0] VERT_MAX_SHIFT = 4'hA;
    localparam logic [9:0] LEVEL_MIDPOINT = 10'h200;
endpackage

// ===== tb/level_regs_monitor.sv
// concurrent checks for the level filter, clamp and power register bank
// assumes it is bound to the bank top and sees only its ports
`timescale 1ns/1ps
module level_regs_monitor (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    input wire logic coarse_clamp_sel_in,
    input wire logic mid_level_clamp_sel_in,
    input wire logic line_update_in,
    input wire logic [3:0] vertical_filter_coeff_out,
    input wire logic [2:0] horizontal_filter_taps_out,
    input wire logic automatic_level_loop_en_out,
    input wire logic [9:0] level_out,
    input wire logic common_mode_offset_en_out,
    input wire logic [1:0] fine_clamp_time_const_out,
    input wire logic fine_clamp_red_en_out,
    input wire logic sog_power_down_out,
    input wire logic red_converter_power_down_out
);
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire logic req;
    wire logic [12:0] cfg;
    assign req = wb_cyc_in && wb_stb_in;
    assign cfg = {vertical_filter_coeff_out, horizontal_filter_taps_out,
        automatic_level_loop_en_out, fine_clamp_time_const_out,
        fine_clamp_red_en_out, sog_power_down_out,
        red_converter_power_down_out};
    property p_answer; $rose(req) && ce_in |=> wb_ack_out || wb_err_out;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack");
    property p_err_pulse; wb_err_out |-> !wb_ack_out ##1 !wb_err_out;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("err");
    property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data leak");
    property p_cm_gate;
        coarse_clamp_sel_in || mid_level_clamp_sel_in
            |-> !common_mode_offset_en_out;
    endproperty
    a_cm_gate: assert property (p_cm_gate) else $error("offset on");
    // settings may only move in the cycle that acknowledges a write
    property p_cfg_hold; !wb_ack_out |-> $stable(cfg); endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("cfg moved");
    property p_loop_frozen;
        !automatic_level_loop_en_out &&
            !$past(automatic_level_loop_en_out) &&
            !$past(automatic_level_loop_en_out, 2) |-> $stable(level_out);
    endproperty
    a_loop_frozen: assert property (p_loop_frozen) else $error("ran");
    property p_level_cause;
        $changed(level_out) |-> $past(line_update_in) ||
            $past(line_update_in, 2);
    endproperty
    a_level_cause: assert property (p_level_cause) else $error("lvl");
    cover property (wb_err_out);
    cover property (coarse_clamp_sel_in && !common_mode_offset_en_out);
    cover property ($changed(level_out));
endmodule
bind level_filter_clamp_power_regs level_regs_monitor u_mon (.*);

// ===== tb/tb.sv
// self-checking bench for the level filter, clamp and power bank
// assumes the bank answers one cycle after it takes a request
`timescale 1ns/1ps
module tb;
    import level_regs_pkg::*;
    // ---------------------------------------------------------------
    // stimulus and checks
    // ---------------------------------------------------------------
    logic clk_in = 0, rst_in = 1, ce = 1, cyc = 0, stb = 0, we = 0;
    logic [9:0] adr = '0, sample = '0;
    logic [3:0] sel = '0;
    logic [31:0] wdat = '0, rd_val;
    logic coarse = 0, mid = 0, svalid = 0, lupd = 0, rd_err;
    wire logic [31:0] rdat;
    wire logic ack, err, loop_en, cm, gb, red_en;
    wire logic sog, slc, rfp, cur, bpd, gpd, rpd;
    wire logic [3:0] vert;
    wire logic [2:0] horz;
    wire logic [1:0] tc;
    wire logic [9:0] level;
    wire logic [7:0] pwr;
    int miscompares = 0, checked = 0, cycles = 0;
    assign pwr = {1'b0, sog, slc, rfp, cur, bpd, gpd, rpd};
    level_filter_clamp_power_regs DUT (.clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
        .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err),
        .coarse_clamp_sel_in(coarse), .mid_level_clamp_sel_in(mid),
        .sample_valid_in(svalid), .sample_in(sample),
        .line_update_in(lupd), .vertical_filter_coeff_out(vert),
        .horizontal_filter_taps_out(horz),
        .automatic_level_loop_en_out(loop_en), .level_out(level),
        .common_mode_offset_en_out(cm), .fine_clamp_time_const_out(tc),
        .fine_clamp_green_blue_en_out(gb), .fine_clamp_red_en_out(red_en),
        .sog_power_down_out(sog), .slicer_power_down_out(slc),
        .reference_power_down_out(rfp), .current_ctrl_power_down_out(cur),
        .blue_converter_power_down_out(bpd),
        .green_converter_power_down_out(gpd),
        .red_converter_power_down_out(rpd));
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // request held until ack or err is sampled, then dropped
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [7:0] d, input logic [1:0] lo = 2'b00,
        input logic [3:0] s = 4'hF);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, lo};
        sel <= s;
        wdat <= {24'h0, d};
        // only the bench timeout ends a wait that never gets an answer
        do begin
            @(posedge clk_in);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd_val = rdat;
        rd_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd_val, {24'h0, exp});
    endtask
    task automatic wr_chk(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
        case (idx)
            IDX_LOOP_FILTER:
                chk(32'({vert, horz}), 32'({d[7:4], d[2:0]}));
            IDX_CLAMP: chk(32'({cm, tc, gb, red_en}),
                32'({d[7], d[4:3], d[1:0]}));
            IDX_POWER: chk(32'(pwr), {25'h0, d[6:0]});
            IDX_FIXED: chk(32'(loop_en), 32'h1);
            default: chk(32'(loop_en), 32'(d[7]));
        endcase
        rd(idx, d);
    endtask
    task automatic line(input logic [9:0] v);
        repeat (2) begin
            @(posedge clk_in);
            sample <= v;
            svalid <= 1'b1;
        end
        @(posedge clk_in);
        svalid <= 1'b0;
        lupd <= 1'b1;
        @(posedge clk_in);
        lupd <= 1'b0;
        // update at the strobe edge, level register one edge later
        repeat (3) @(posedge clk_in);
    endtask
    task automatic t_reset;
        @(posedge clk_in);
        chk(32'({vert, horz, loop_en}), 32'hA7);
        chk(32'(level), 32'h200);
        chk(32'({cm, tc, gb, red_en}), 32'h03);
        chk(32'(pwr), 32'h00);
        rd(IDX_FIXED, 8'h08);
        rd(IDX_CLAMP, 8'h07);
        rd(IDX_POWER, 8'h00);
        rd(IDX_LOOP_ENABLE, 8'h80);
        rd(IDX_LOOP_FILTER, RST_LOOP_FILTER);
        $display("reset values test done");
    endtask
    task automatic t_fields;
        for (int i = 0; i < 8; i++) begin
            wr_chk(IDX_POWER, 8'h7F >> i);
        end
        wr_chk(IDX_POWER, 8'h2A);
        wr_chk(IDX_POWER, 8'h55);
        wr_chk(IDX_POWER, 8'h00);
        wr_chk(IDX_CLAMP, 8'h9C);
        wr_chk(IDX_CLAMP, 8'h0E);
        wr_chk(IDX_CLAMP, 8'h15);
        for (int c = 0; c < 16; c++) begin
            wr_chk(IDX_LOOP_FILTER, 8'(c * 17));
        end
        wr_chk(IDX_FIXED, 8'h08);
        $display("field mapping test done");
    endtask
    task automatic t_cm_gate;
        wr_chk(IDX_CLAMP, 8'h87);
        for (int i = 1; i < 4; i++) begin
            @(posedge clk_in);
            coarse <= i[0];
            mid <= i[1];
            @(posedge clk_in);
            chk(32'(cm), 32'h0);
        end
        coarse <= 1'b0;
        mid <= 1'b0;
        wr_chk(IDX_CLAMP, 8'h07);
        $display("offset gating test done");
    endtask
    task automatic t_errors;
        xfer(1'b1, 8'h30, 8'h55);
        chk(32'(rd_err), 32'h1);
        xfer(1'b1, IDX_POWER, 8'h55, 2'b10);
        chk(32'(rd_err), 32'h1);
        xfer(1'b1, IDX_LEVEL_LO, 8'h55);
        chk(32'(rd_err), 32'h1);
        xfer(1'b1, IDX_POWER, 8'hFF, 2'b00, 4'hE);
        rd(IDX_POWER, 8'h00);
        $display("refusal test done");
    endtask
    task automatic t_level;
        wr_chk(IDX_LOOP_FILTER, 8'h00);
        line(10'h100);
        chk(32'(level), 32'h300);
        rd(IDX_LEVEL_LO, 8'h00);
        rd(IDX_LEVEL_HI, 8'h03);
        wr_chk(IDX_LOOP_ENABLE, 8'h00);
        line(10'h3FF);
        chk(32'(level), 32'h300);
        wr_chk(IDX_LOOP_ENABLE, 8'h80);
        wr_chk(IDX_LOOP_FILTER, 8'h10);
        line(10'h300);
        chk(32'(level), 32'h000);
        $display("level loop test done");
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_fields();
        t_cm_gate();
        t_errors();
        t_level();
        final_report();
    end
endmodule
